// file: hdl/htc_compare_stage.sv
// Purpose: Compare, flag, waveform, dead-time and pin override of the timer.
// Assumes: Counter unit outside supplies count, direction, top and bottom.
// Notes: APB slave, always ready, errors on unmapped addresses.
// Contract
// - Compare counter against all four compare values.
// - Flags A, B, D set one cycle later.
// - Flag and enable raise interrupt request.
// - Flag clears on service or one written.
// - PWM writes buffered, normal writes direct.
// - Buffer moves to active at top/bottom.
// - Read returns latest written compare value.
// - Force strobe acts like match, non-PWM.
// - Force sets no flag, no counter reload.
// - Counter write blocks next-cycle matches.
// - Action bits take effect immediately.
// - Output state kept across mode changes.
// - PWM with action 01 gives pair.
// - Three independent dead-time generators.
// - Dead-time prescaler divides by 1,2,4,8.
// - Edge loads counter; rise waits zero.
// - High field rising, low field falling.
// - Outputs lag waveform at least one cycle.
// - Inversion bit inverts both pair outputs.
// - Normal mode: one-cycle synchroniser only.
// - Other PWM actions behave as normal.
// - Reset clears all compare outputs.
// - Nonzero action overrides port data value.
// - Compare top value feeds counter top.
// - Action zero leaves waveform untouched.
// - Normal toggle action toggles on match.
`timescale 1ns/100ps
`default_nettype none
module htc_compare_stage (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [htc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter unit.
  input wire logic [htc_pkg::CW-1:0] counter_value,
  input wire logic count_up,
  input wire logic at_top,
  input wire logic at_bottom,
  output logic counter_load,
  output logic [htc_pkg::CW-1:0] counter_load_value,
  output logic [htc_pkg::CW-1:0] compare_value_top,
  // Interrupt requests and service acknowledges.
  output logic [htc_pkg::NCH-1:0] irq_req,
  input wire logic [htc_pkg::NCH-1:0] irq_ack,
  // General port and pins, two per channel: main then complement.
  input wire logic [2*htc_pkg::NCH-1:0] port_data,
  input wire logic [2*htc_pkg::NCH-1:0] port_dir,
  output logic [2*htc_pkg::NCH-1:0] pin_out,
  output logic [2*htc_pkg::NCH-1:0] pin_oe
);
  import htc_pkg::*;

  // Address decoder, shared by the write, read and side-effect paths.
  function automatic htc_reg_t htc_decode(input logic [AW-1:0] a);
    if (a == OFS_CTRL) return HTC_RG_CTRL;
    else if (a == OFS_ACTION) return HTC_RG_ACTION;
    else if (a == OFS_CMP_A) return HTC_RG_CMP_A;
    else if (a == OFS_CMP_B) return HTC_RG_CMP_B;
    else if (a == OFS_CMP_TOP) return HTC_RG_CMP_TOP;
    else if (a == OFS_CMP_D) return HTC_RG_CMP_D;
    else if (a == OFS_COUNT) return HTC_RG_COUNT;
    else if (a == OFS_HIGH) return HTC_RG_HIGH;
    else if (a == OFS_GAP) return HTC_RG_GAP;
    else if (a == OFS_FLAGS) return HTC_RG_FLAGS;
    else if (a == OFS_IRQ_EN) return HTC_RG_IRQ_EN;
    else if (a == OFS_FORCE) return HTC_RG_FORCE;
    else return HTC_RG_NONE;
  endfunction

  // Output channel to compare index: A, B, then D (top sits between).
  function automatic int htc_ch_cmp(input int c);
    return (c == NCH - 1) ? NCMP - 1 : c;
  endfunction

  // Software-visible state.
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next; // Modes, shape, invert, prescale.
  logic [2*NCH-1:0] act_reg, act_next; // Output action per channel.
  logic [CW-1:0] cmp_buf_reg [NCMP]; // Latest written compare values.
  logic [CW-1:0] cmp_buf_next [NCMP];
  logic [CW-1:0] cmp_act_reg [NCMP]; // Values the comparator uses.
  logic [CW-1:0] cmp_act_next [NCMP];
  logic [1:0] high_reg, high_next; // Shared high bits.
  logic [7:0] gap_reg, gap_next; // Rise and fall dead-time fields.
  logic [NCH-1:0] flag_reg, flag_next; // Match flags A, B, D.
  logic [NCH-1:0] ien_reg, ien_next; // Interrupt enables.
  logic [NCH-1:0] wave_reg, wave_next; // Raw waveforms.
  logic block_reg, block_next; // Matches blocked this cycle.
  logic load_reg, load_next;
  logic [CW-1:0] load_val_reg, load_val_next;
  logic [2:0] div_reg, div_next; // Dead-time prescaler.
  logic [31:0] prdata_reg, prdata_next;

  // Decoded bus phase.
  htc_reg_t sel;
  logic wr, rd, setup_rd;
  logic pwm_any, shape, upd_pt, gap_tick;
  logic [2:0] ps_mask;
  logic [NCMP-1:0] match_raw, match_ev;
  logic [NCH-1:0] clr, force_ev;
  logic [NCH-1:0] pwm_ch;
  logic [NCH-1:0] main_o, comp_o;
  int ci;

  // Bus handshake; the slave never inserts wait states.
  always_comb begin
    sel = htc_decode(paddr);
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    setup_rd = psel && !penable && !pwrite;
    pready = 1'b1;
    pslverr = psel && penable && (sel == HTC_RG_NONE);
  end

  // Mode decode and comparators, including the top value.
  always_comb begin
    pwm_ch = ctrl_reg[CTRL_PWM_LSB +: NCH];
    pwm_any = |pwm_ch;
    shape = ctrl_reg[CTRL_SHAPE];
    // Fast shape reloads at top, the dual-slope shape at bottom.
    upd_pt = shape ? at_bottom : at_top;
    for (int i = 0; i < NCMP; i++) begin
      match_raw[i] = counter_value == cmp_act_reg[i];
    end
    match_ev = block_reg ? '0 : match_raw;
    ps_mask = (3'h1 << ctrl_reg[CTRL_PS_LSB +: 2]) - 3'h1;
    gap_tick = (div_reg & ps_mask) == 3'h0;
    div_next = div_reg + 3'h1;
  end

  // Register writes, compare buffering, flags and read side effects.
  always_comb begin
    ctrl_next = ctrl_reg;
    act_next = act_reg;
    high_next = high_reg;
    gap_next = gap_reg;
    ien_next = ien_reg;
    load_next = 1'b0;
    load_val_next = load_val_reg;
    block_next = wr && (sel == HTC_RG_COUNT);
    ci = int'(sel) - int'(HTC_RG_CMP_A);
    for (int i = 0; i < NCMP; i++) begin
      cmp_buf_next[i] = cmp_buf_reg[i];
    end
    if (wr) begin
      if (sel == HTC_RG_CTRL) begin
        ctrl_next = pwdata[CTRL_W-1:0];
      end else if (sel == HTC_RG_ACTION) begin
        act_next = pwdata[2*NCH-1:0];
      end else if (ci >= 0 && ci < NCMP) begin
        cmp_buf_next[ci] = {high_reg, pwdata[7:0]};
      end else if (sel == HTC_RG_COUNT) begin
        load_next = 1'b1;
        load_val_next = {high_reg, pwdata[7:0]};
      end else if (sel == HTC_RG_HIGH) begin
        high_next = pwdata[1:0];
      end else if (sel == HTC_RG_GAP) begin
        gap_next = pwdata[7:0];
      end else if (sel == HTC_RG_IRQ_EN) begin
        ien_next = pwdata[NCH-1:0];
      end
    end
    // A low-byte read parks the upper bits for the next access.
    if (rd && ci >= 0 && ci < NCMP) begin
      high_next = cmp_buf_reg[ci][CW-1:8];
    end else if (rd && sel == HTC_RG_COUNT) begin
      high_next = counter_value[CW-1:8];
    end
    // Normal mode bypasses the buffer; PWM waits for the update point.
    for (int i = 0; i < NCMP; i++) begin
      if (!pwm_any) begin
        cmp_act_next[i] = cmp_buf_next[i];
      end else if (upd_pt) begin
        cmp_act_next[i] = cmp_buf_reg[i];
      end else begin
        cmp_act_next[i] = cmp_act_reg[i];
      end
    end
    // Set wins over clear so an event in the clearing cycle survives.
    clr = irq_ack;
    if (wr && sel == HTC_RG_FLAGS) begin
      clr = clr | pwdata[NCH-1:0];
    end
    for (int c = 0; c < NCH; c++) begin
      flag_next[c] = (flag_reg[c] && !clr[c]) || match_ev[htc_ch_cmp(c)];
    end
  end

  // Waveform generator per channel.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      force_ev[c] = wr && (sel == HTC_RG_FORCE) && pwdata[c] && !pwm_ch[c];
      wave_next[c] = wave_reg[c];
      if (act_reg[2*c +: 2] != ACT_NONE) begin
        if (!pwm_ch[c]) begin
          // A forced match changes only the waveform, never flags or count.
          if (match_ev[htc_ch_cmp(c)] || force_ev[c]) begin
            if (act_reg[2*c +: 2] == ACT_PAIR) begin
              wave_next[c] = !wave_reg[c];
            end else begin
              wave_next[c] = act_reg[2*c +: 2] == ACT_SET;
            end
          end
        end else if (!shape) begin
          if (match_ev[htc_ch_cmp(c)]) begin
            wave_next[c] = act_reg[2*c +: 2] == ACT_SET;
          end else if (at_bottom) begin
            wave_next[c] = act_reg[2*c +: 2] != ACT_SET;
          end
        end else if (match_ev[htc_ch_cmp(c)]) begin
          wave_next[c] = (act_reg[2*c +: 2] == ACT_SET) ~^ count_up;
        end
      end
    end
  end

  // Read data is captured in the setup phase and held through access.
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = '0;
      if (sel == HTC_RG_CTRL) begin
        prdata_next[CTRL_W-1:0] = ctrl_reg;
      end else if (sel == HTC_RG_ACTION) begin
        prdata_next[2*NCH-1:0] = act_reg;
      end else if (ci >= 0 && ci < NCMP) begin
        prdata_next[CW-1:0] = cmp_buf_reg[ci];
      end else if (sel == HTC_RG_COUNT) begin
        prdata_next[CW-1:0] = counter_value;
      end else if (sel == HTC_RG_HIGH) begin
        prdata_next[1:0] = high_reg;
      end else if (sel == HTC_RG_GAP) begin
        prdata_next[7:0] = gap_reg;
      end else if (sel == HTC_RG_FLAGS) begin
        prdata_next[NCH-1:0] = flag_reg;
      end else if (sel == HTC_RG_IRQ_EN) begin
        prdata_next[NCH-1:0] = ien_reg;
      end
    end
  end

  // All state registers; reset leaves the waveforms low and top at default.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '0;
      act_reg <= '0;
      high_reg <= '0;
      gap_reg <= '0;
      flag_reg <= '0;
      ien_reg <= '0;
      wave_reg <= '0;
      block_reg <= 1'b0;
      load_reg <= 1'b0;
      load_val_reg <= '0;
      div_reg <= '0;
      prdata_reg <= '0;
      for (int i = 0; i < NCMP; i++) begin
        cmp_buf_reg[i] <= (i == CMP_TOP_IDX) ? TOP_RESET : CMP_RESET;
        cmp_act_reg[i] <= (i == CMP_TOP_IDX) ? TOP_RESET : CMP_RESET;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      act_reg <= act_next;
      high_reg <= high_next;
      gap_reg <= gap_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      wave_reg <= wave_next;
      block_reg <= block_next;
      load_reg <= load_next;
      load_val_reg <= load_val_next;
      div_reg <= div_next;
      prdata_reg <= prdata_next;
      for (int i = 0; i < NCMP; i++) begin
        cmp_buf_reg[i] <= cmp_buf_next[i];
        cmp_act_reg[i] <= cmp_act_next[i];
      end
    end
  end

  // One dead-time generator per output channel.
  for (genvar g = 0; g < NCH; g++) begin : g_gap
    htc_gap_gen u_gap (
      .sys_clk(sys_clk),
      .rst(rst),
      .raw_waveform(wave_reg[g]),
      .pair_enable(pwm_ch[g] && act_reg[2*g +: 2] == ACT_PAIR),
      .pair_invert(ctrl_reg[CTRL_INV]),
      .gap_tick(gap_tick),
      .rise_gap_count(gap_reg[GAP_RISE_LSB +: GW]),
      .fall_gap_count(gap_reg[GAP_FALL_LSB +: GW]),
      .out_main(main_o[g]),
      .out_comp(comp_o[g])
    );
  end

  // Pin override; direction always stays with the port direction bits.
  always_comb begin
    pin_oe = port_dir;
    for (int c = 0; c < NCH; c++) begin
      pin_out[2*c] = (act_reg[2*c +: 2] != ACT_NONE) ? main_o[c] : port_data[2*c];
      pin_out[2*c+1] = (act_reg[2*c +: 2] != ACT_NONE) ? comp_o[c] : port_data[2*c+1];
    end
  end

  // Remaining outputs.
  assign irq_req = flag_reg & ien_reg;
  assign counter_load = load_reg;
  assign counter_load_value = load_val_reg;
  assign compare_value_top = cmp_act_reg[CMP_TOP_IDX];
  assign prdata = prdata_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_flag_set;
    match_ev[0] |=> flag_reg[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag A not set");
  property p_irq;
    match_ev[1] && ien_reg[1] && !(wr && sel == HTC_RG_IRQ_EN) |=> irq_req[1];
  endproperty
  a_irq: assert property (p_irq) else $error("irq B missing");
  property p_w1c;
    wr && sel == HTC_RG_FLAGS && pwdata[0] && !match_ev[0] |=> !flag_reg[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag A not cleared");
  property p_direct;
    wr && sel == HTC_RG_CMP_A && !pwm_any |=>
      cmp_act_reg[0] == {$past(high_reg), $past(pwdata[7:0])};
  endproperty
  a_direct: assert property (p_direct) else $error("direct write lost");
  property p_hold;
    pwm_any && !upd_pt |=> cmp_act_reg[1] == $past(cmp_act_reg[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer moved early");
  property p_readback;
    setup_rd && sel == HTC_RG_CMP_TOP |=> prdata[CW-1:0] == $past(cmp_buf_reg[CMP_TOP_IDX]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback stale");
  property p_force;
    force_ev[0] && act_reg[1:0] == ACT_PAIR && !match_ev[0] |=>
      wave_reg[0] != $past(wave_reg[0]) && !counter_load;
  endproperty
  a_force: assert property (p_force) else $error("force wrong");
  property p_block;
    wr && sel == HTC_RG_COUNT |=> match_ev == '0 ##1 counter_load == 1'b0;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");
  c_force: cover property (force_ev[0]);
  c_update: cover property (pwm_any && upd_pt && cmp_buf_reg[0] != cmp_act_reg[0]);
  c_irq: cover property ($rose(irq_req[2]));
endmodule // htc_compare_stage
`default_nettype wire

// file: hdl/htc_pkg.sv
// Purpose: Shared constants for the timer compare and dead-time stage.
// Assumes: 32-bit APB data, byte addresses, one register per word.
// Notes: Values of 10 bits are formed from a low byte and shared high bits.
package htc_pkg;
  // Widths and counts.
  localparam int CW = 10;
  localparam int NCH = 3;
  localparam int NCMP = 4;
  localparam int GW = 4;
  localparam int AW = 8;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACTION = 8'h04;
  localparam logic [7:0] OFS_CMP_A = 8'h08;
  localparam logic [7:0] OFS_CMP_B = 8'h0c;
  localparam logic [7:0] OFS_CMP_TOP = 8'h10;
  localparam logic [7:0] OFS_CMP_D = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_HIGH = 8'h1c;
  localparam logic [7:0] OFS_GAP = 8'h20;
  localparam logic [7:0] OFS_FLAGS = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] OFS_FORCE = 8'h2c;
  // Control register fields.
  localparam int CTRL_PWM_LSB = 0;
  localparam int CTRL_SHAPE = 3;
  localparam int CTRL_INV = 4;
  localparam int CTRL_PS_LSB = 5;
  localparam int CTRL_W = 7;
  // Dead-time register fields.
  localparam int GAP_RISE_LSB = 4;
  localparam int GAP_FALL_LSB = 0;
  // Output action codes.
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_PAIR = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Reset values.
  localparam logic [9:0] TOP_RESET = 10'h0ff;
  localparam logic [9:0] CMP_RESET = 10'h000;
  localparam int CMP_TOP_IDX = 2;
  // Register selector produced by the address decoder.
  typedef enum logic [3:0] {
    HTC_RG_CTRL, HTC_RG_ACTION, HTC_RG_CMP_A, HTC_RG_CMP_B, HTC_RG_CMP_TOP,
    HTC_RG_CMP_D, HTC_RG_COUNT, HTC_RG_HIGH, HTC_RG_GAP, HTC_RG_FLAGS,
    HTC_RG_IRQ_EN, HTC_RG_FORCE, HTC_RG_NONE
  } htc_reg_t;
endpackage

// file: hdl/htc_gap_gen.sv
// Purpose: One dead-time generator for a complementary output pair.
// Assumes: Waveform and prescaled tick come from the same clock.
// Notes: With pairing off it is a plain one-cycle synchroniser.
`timescale 1ns/100ps
`default_nettype none
module htc_gap_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Waveform and controls.
  input wire logic raw_waveform,
  input wire logic pair_enable,
  input wire logic pair_invert,
  input wire logic gap_tick,
  input wire logic [htc_pkg::GW-1:0] rise_gap_count,
  input wire logic [htc_pkg::GW-1:0] fall_gap_count,
  // Output pair.
  output logic out_main,
  output logic out_comp
);
  import htc_pkg::*;
  logic raw_reg, raw_next; // Last waveform, for edge detection.
  logic [GW-1:0] cnt_reg, cnt_next; // Dead-time down counter.
  logic main_reg, main_next;
  logic comp_reg, comp_next;
  logic edge_seen;
  logic busy;

  // Load on an edge, count down on ticks, and hold the rising side off.
  always_comb begin
    edge_seen = raw_waveform != raw_reg;
    busy = edge_seen || (cnt_reg != '0);
    raw_next = raw_waveform;
    cnt_next = cnt_reg;
    if (edge_seen) begin
      cnt_next = raw_waveform ? rise_gap_count : fall_gap_count;
    end else if (gap_tick && cnt_reg != '0) begin
      cnt_next = cnt_reg - GW'(1);
    end
    if (pair_enable) begin
      // Both sides stay inactive while the gap runs; inversion flips both.
      main_next = (raw_waveform && !busy) ^ pair_invert;
      comp_next = (!raw_waveform && !busy) ^ pair_invert;
    end else begin
      main_next = raw_waveform;
      comp_next = !raw_waveform;
    end
  end

  // Register stage; reset drives both outputs low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_reg <= 1'b0;
      cnt_reg <= '0;
      main_reg <= 1'b0;
      comp_reg <= 1'b0;
    end else begin
      raw_reg <= raw_next;
      cnt_reg <= cnt_next;
      main_reg <= main_next;
      comp_reg <= comp_next;
    end
  end
  assign out_main = main_reg;
  assign out_comp = comp_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rise_held;
    pair_enable && !pair_invert && $rose(raw_waveform) |=> !out_main;
  endproperty
  a_rise_held: assert property (p_rise_held) else $error("main rose without gap");
  property p_sync_lag;
    !pair_enable |=> out_main == $past(raw_waveform);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("sync lag wrong");
  c_pair_edge: cover property (pair_enable && $rose(raw_waveform) ##[1:40] out_main);
endmodule // htc_gap_gen
`default_nettype wire

// file: verification/htc_switch_model.sv
// Purpose: Model of the power switch drivers hanging on the output pairs.
// Assumes: Pins are sampled on the timer clock; a pin is on at its active level.
// Notes: Counts cycles in which both switches of pair A conduct together.
`timescale 1ns/100ps
`default_nettype none
module htc_switch_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Pins and watch controls.
  input wire logic [5:0] pin_out,
  input wire logic pair_watch,
  input wire logic invert,
  // Result.
  output int overlap_count
);
  // Both switches on at once would short the supply, so each such cycle is counted.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      overlap_count <= 0;
    end else if (pair_watch && pin_out[1:0] === (invert ? 2'b00 : 2'b11)) begin
      overlap_count <= overlap_count + 1;
    end
  end
endmodule // htc_switch_model
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Self-checking bench of the compare and dead-time stage.
// Assumes: The counter unit is played by the bench through counter_value.
// Notes: Register traffic goes over APB with the apb task only.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  import htc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, at_top = 1'b0, at_bottom = 1'b0, counter_load;
  logic [9:0] counter_value = 10'h000, counter_load_value, compare_value_top;
  logic [2:0] irq_req, irq_ack = 3'h0;
  logic [5:0] port_data = 6'h15, port_dir = 6'h2a, pin_out, pin_oe;
  logic pair_watch = 1'b0, inv_watch = 1'b0, count_up = 1'b1;
  int num_errors = 0, total_checks = 0, overlaps, n;
  int codes[3] = '{3, 2, 1}, levels[3] = '{1, 0, 1};
  htc_compare_stage htc_compare_stage_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_value(counter_value), .count_up(count_up),
    .at_top(at_top), .at_bottom(at_bottom), .counter_load(counter_load),
    .counter_load_value(counter_load_value), .compare_value_top(compare_value_top),
    .irq_req(irq_req), .irq_ack(irq_ack), .port_data(port_data), .port_dir(port_dir),
    .pin_out(pin_out), .pin_oe(pin_oe));
  htc_switch_model htc_switch_model_i (.sys_clk(sys_clk), .rst(rst), .pin_out(pin_out),
    .pair_watch(pair_watch), .invert(inv_watch), .overlap_count(overlaps));
  // Free-running 100 MHz timer clock.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // Only the bench timeout may end this wait.
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // One match of compare A: counter sits on the value for one cycle.
  task automatic hit();
    @(posedge sys_clk);
    counter_value <= 10'h055;
    @(posedge sys_clk);
    counter_value <= 10'h056;
    #1;
  endtask
  // Counts and verdict; the only end of the run.
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hang is cut short well above the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `CHK({pready, pslverr, pin_out}, {2'b10, port_data})
    apb(0, OFS_CMP_TOP, 0); `CHK(rdat[9:0], 10'h0ff)
    apb(0, 8'h3c, 0); `CHK({rerr, rdat}, 33'h100000000)
    $display("test reset done");
    apb(1, OFS_IRQ_EN, 32'h7); #1; `CHK(irq_req, 3'h7)
    apb(1, OFS_CMP_A, 32'h55); apb(0, OFS_CMP_A, 0); `CHK(rdat[9:0], 10'h055)
    apb(1, OFS_FLAGS, 32'h1); #1; `CHK(irq_req, 3'h6)
    hit(); `CHK(irq_req[0], 1'b1)
    @(posedge sys_clk); irq_ack <= 3'h1; @(posedge sys_clk); irq_ack <= 3'h0; #1;
    `CHK(irq_req[0], 1'b0)
    hit(); apb(1, OFS_FLAGS, 32'h1); #1; `CHK(irq_req[0], 1'b0)
    $display("test flags done");
    apb(1, OFS_COUNT, 32'h55);
    counter_value <= 10'h055;
    #1; `CHK({counter_load, counter_load_value}, 11'h455)
    @(posedge sys_clk); counter_value <= 10'h056; @(posedge sys_clk); #1;
    `CHK(irq_req[0], 1'b0)
    $display("test blocking done");
    for (int i = 0; i < 3; i++) begin
      apb(1, OFS_ACTION, codes[i]); apb(1, OFS_FORCE, 32'h1);
      repeat (3) @(posedge sys_clk); #1;
      `CHK(pin_out[0], levels[i][0])
      `CHK({irq_req[0], counter_load}, 2'b00)
    end
    $display("test force done");
    apb(1, OFS_CTRL, 32'h1); apb(1, OFS_CMP_TOP, 32'h80);
    apb(0, OFS_CMP_TOP, 0); `CHK(rdat[9:0], 10'h080)
    `CHK(compare_value_top, 10'h0ff)
    @(posedge sys_clk); at_top <= 1'b1; @(posedge sys_clk); at_top <= 1'b0;
    @(posedge sys_clk); #1; `CHK(compare_value_top, 10'h080)
    $display("test buffering done");
    apb(1, OFS_GAP, 32'h32); apb(1, OFS_ACTION, 32'h1);
    for (int ps = 0; ps < 2; ps++) begin
      apb(1, OFS_CTRL, 32'h1 | (ps << CTRL_PS_LSB));
      pair_watch <= 1'b1;
      hit(); repeat (20) @(posedge sys_clk); #1;
      `CHK(pin_out[1:0], 2'b10)
      @(posedge sys_clk); at_bottom <= 1'b1; @(posedge sys_clk); at_bottom <= 1'b0; #1;
      n = 1;
      while (pin_out[0] !== 1'b1 && n < 40) begin
        @(posedge sys_clk); #1; n++;
      end
      `CHK(n >= 3 + 2 * (1 << ps) && n <= 4 + 4 * (1 << ps), 1'b1)
    end
    pair_watch <= 1'b0;
    apb(1, OFS_CTRL, 32'h1 | (1 << CTRL_INV));
    repeat (4) @(posedge sys_clk); #1;
    `CHK(pin_out[1:0], 2'b10)
    `CHK(overlaps, 0)
    `CHK(pin_oe, port_dir)
    $display("test pair done");
    // Dual-slope shape with a plain action: an up match clears, a down match sets.
    apb(1, OFS_CTRL, 32'h1 | (1 << CTRL_SHAPE)); apb(1, OFS_ACTION, 32'h2);
    for (int d = 1; d >= 0; d--) begin
      @(posedge sys_clk); count_up <= d[0];
      hit(); repeat (2) @(posedge sys_clk); #1;
      `CHK(pin_out[1:0], d ? 2'b10 : 2'b01)
    end
    $display("test dual slope done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
